// >>> cpu_flags_pkg.sv
// Purpose: shared constants, types and helpers of the condition-flag block
// Assumes: 32-bit APB data, one register per aligned word
// Notes: offsets, flag and operation field positions and the flag and bank pointer reset values live here once
package cpu_flags_pkg;

    // apb geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFS_CONDITION_CODE = 8'h00;
    localparam logic [7:0] OFS_BANK_POINTER = 8'h04;
    localparam logic [7:0] OFS_OPERATION = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_GPR_BASE = 8'h20;
    localparam logic [7:0] GPR_WINDOW_MASK = 8'hE0;

    // condition_code bit positions
    localparam int CC_CARRY = 0;
    localparam int CC_OVERFLOW = 1;
    localparam int CC_ZERO = 2;
    localparam int CC_NEGATIVE = 3;
    localparam int CC_LEVEL_LOW = 4;
    localparam int CC_LEVEL_HIGH = 5;
    localparam int CC_INT_ENABLE = 6;
    localparam int CC_HALF_CARRY = 7;

    // reset values: interrupts off, allowed level 3 (lowest)
    localparam logic [7:0] CONDITION_CODE_RESET = 8'h30;
    localparam logic [4:0] BANK_POINTER_RESET = 5'h00;

    // operation register fields
    localparam int OPN_A_LSB = 0;
    localparam int OPN_B_LSB = 8;
    localparam int OPN_CODE_LSB = 16;

    // register bank geometry
    localparam int BANK_COUNT = 32;
    localparam int REGS_PER_BANK = 8;
    localparam int BANK_W = 5;
    localparam int REG_W = 3;

    // arithmetic and shift operations
    typedef enum logic [2:0] {
        OP_ADD,
        OP_ADC,
        OP_SUB,
        OP_SBC,
        OP_SHL,
        OP_SHR
    } op_t;

    // register address: banks are consecutive eight-byte regions
    function automatic logic [BANK_W+REG_W-1:0] gpr_addr(input logic [BANK_W-1:0] bank,
                                                         input logic [REG_W-1:0] regnum);
        gpr_addr = {bank, regnum};
    endfunction

    // priority level of a two-bit level code; smaller number is higher
    function automatic logic [1:0] level_of(input logic [1:0] code);
        level_of = (code == 2'h0) ? 2'h1 : code;
    endfunction

endpackage

// >>> alu_if.sv
// Purpose: carries operands and flag results between the core and the flag unit
// Assumes: purely combinational path
// Notes: requester drives operands, unit returns result and flags
`timescale 1ns/1ps
interface alu_if;
    import cpu_flags_pkg::*;
    logic [7:0] a;      // first operand
    logic [7:0] b;      // second operand
    op_t op;            // operation code
    logic cin;          // incoming carry
    logic [7:0] result; // operation result
    logic half;         // carry between nibbles
    logic neg;          // sign of result
    logic zero;         // result is zero
    logic ovf;          // two's complement overflow
    logic carry;        // carry out, borrow or shifted-out bit
    logic legal;        // operation code is known

    modport requester(output a, b, op, cin, input result, half, neg, zero, ovf, carry, legal);
    modport unit(input a, b, op, cin, output result, half, neg, zero, ovf, carry, legal);
endinterface

// >>> flag_unit.sv
// Purpose: computes an 8-bit result and its five condition flags
// Assumes: combinational, sampled by the caller
// Notes: shifts clear overflow and leave half-carry zero
`timescale 1ns/1ps
module flag_unit
    import cpu_flags_pkg::*;
(
    // operand and flag carrier
    alu_if.unit alu
);

    logic [8:0] wide;   // nine-bit sum or difference
    logic [4:0] nib;    // low nibble with carry

    // result and flags from operands
    always_comb begin
        wide = 9'h000;
        nib = 5'h00;
        alu.half = 1'b0;
        alu.ovf = 1'b0;
        alu.carry = 1'b0;
        alu.legal = 1'b1;
        unique case (alu.op)
            OP_ADD, OP_ADC: begin
                // carry in only for add-with-carry
                wide = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, alu.op == OP_ADC && alu.cin};
                nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]}
                      + {4'h0, alu.op == OP_ADC && alu.cin};
                alu.half = nib[4];
                alu.carry = wide[8];
                alu.ovf = (alu.a[7] == alu.b[7]) && (wide[7] != alu.a[7]);
            end
            OP_SUB, OP_SBC: begin
                // borrow in only for subtract-with-borrow
                wide = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, alu.op == OP_SBC && alu.cin};
                nib = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]}
                      - {4'h0, alu.op == OP_SBC && alu.cin};
                alu.half = nib[4];
                alu.carry = wide[8];
                alu.ovf = (alu.a[7] != alu.b[7]) && (wide[7] != alu.a[7]);
            end
            OP_SHL: begin
                // bit 7 falls out into carry
                wide = {1'b0, alu.a[6:0], 1'b0};
                alu.carry = alu.a[7];
            end
            OP_SHR: begin
                // bit 0 falls out into carry
                wide = {2'b00, alu.a[7:1]};
                alu.carry = alu.a[0];
            end
            default: begin
                // unknown code: nothing happens
                alu.legal = 1'b0;
            end
        endcase
        alu.result = wide[7:0];
        alu.neg = wide[7];
        alu.zero = (wide[7:0] == 8'h00);
    end

endmodule // flag_unit

// >>> gpr_mem.sv
// Purpose: banked general-purpose register storage
// Assumes: one write port, one read port, read data registered
// Notes: read data follows the address by one clock
`timescale 1ns/1ps
module gpr_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    // clock
    input wire logic pclk,
    // write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // read side
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] cells [DEPTH]; // register cells, no reset needed

    // write and registered read
    always_ff @(posedge pclk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
        rdata <= cells[raddr];
    end

endmodule // gpr_mem

// >>> cpu_condition_flags.sv
// Purpose: condition flags, interrupt gating and banked register access
// Assumes: APB slave, every access completes with one wait state
// Notes: writing the operation register runs one arithmetic or shift step
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module cpu_condition_flags
    import cpu_flags_pkg::*;
#(
    parameter int BANKS = BANK_COUNT,
    parameter int REGS = REGS_PER_BANK
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt request from peripherals
    input wire logic irq_req,
    input wire logic [1:0] irq_level,
    // interrupt accepted toward the sequencer
    output logic irq_accept
);

    // architectural state
    // flag register, bank pointer and last result are software visible
    logic [7:0] condition_code;   // flags, level field, enable
    logic [BANK_W-1:0] bank_pointer; // active register bank
    logic [7:0] result;           // last operation result

    // next values
    // each group of state has one next-value process and one register process
    logic [7:0] next_condition_code;
    logic [BANK_W-1:0] next_bank_pointer;
    logic [7:0] next_result;
    logic [DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq_accept;

    // decode helpers
    // all decode is combinational from the bus inputs of the current cycle and the block's own registers
    logic access_end;     // access phase ends at this edge
    logic data_phase;     // first access cycle, answer is prepared
    logic wr_done;        // write takes effect at this edge
    logic sel_cc;         // condition_code addressed
    logic sel_bank;       // bank pointer addressed
    logic sel_opn;        // operation register addressed
    logic sel_res;        // result addressed
    logic sel_stat;       // status addressed
    logic sel_gpr;        // register window addressed
    logic mapped;         // any known register
    logic [7:0] mem_rdata; // register storage read data
    logic [BANK_W+REG_W-1:0] mem_addr; // register storage address
    logic [1:0] allowed;  // allowed level code
    logic cc_write;       // software write to the flag register
    logic bank_write;     // software write to the bank pointer
    logic op_step;        // operation write runs one step
    logic [DATA_W-1:0] read_word; // read multiplexer output
    logic [1:0] level_req;   // request level number
    logic [1:0] level_allow; // allowed level number
    logic level_above;    // request strictly above allowed

    // arithmetic carrier
    // operands come straight from the write data, so the step result is
    // ready in the same cycle as the completing edge of the write
    // and no operand latch is needed
    alu_if alu ();

    // flag computation
    flag_unit u_flag_unit (
        .alu(alu.unit)
    );

    // banked register storage
    // storage is not reset: a register reads unknown until first written
    // one read port, shared address with the write port
    gpr_mem #(
        .DEPTH(BANKS * REGS),
        .AW(BANK_W + REG_W)
    ) u_gpr_mem (
        .pclk(pclk),
        .we(wr_done && sel_gpr),
        .waddr(mem_addr),
        .wdata(pwdata[7:0]),
        .raddr(mem_addr),
        .rdata(mem_rdata)
    );

    // operand fields straight from the write data; the carry in is the
    // stored carry flag, so chained adds and subtracts span several steps
    assign alu.a = pwdata[OPN_A_LSB +: 8];
    assign alu.b = pwdata[OPN_B_LSB +: 8];
    assign alu.op = op_t'(pwdata[OPN_CODE_LSB +: 3]);
    assign alu.cin = condition_code[CC_CARRY];

    // address decode: exact word offsets, storage window by mask
    // an unaligned address inside the window is refused, so a stray
    // byte access never aliases onto a neighbouring register
    always_comb begin
        // single-word registers at their byte offsets
        sel_cc = (paddr == OFS_CONDITION_CODE);
        sel_bank = (paddr == OFS_BANK_POINTER);
        sel_opn = (paddr == OFS_OPERATION);
        sel_res = (paddr == OFS_RESULT);
        sel_stat = (paddr == OFS_STATUS);
        // aligned words in the window only
        sel_gpr = ((paddr & GPR_WINDOW_MASK) == OFS_GPR_BASE) && (paddr[1:0] == 2'b00);
        // anything else answers with an error
        mapped = sel_cc || sel_bank || sel_opn || sel_res || sel_stat || sel_gpr;
    end

    // transfer phase tracking
    // the answer is prepared in the first access cycle and every effect
    // is taken at the edge that shows pready high, never earlier
    always_comb begin
        // first access cycle, pready still low
        data_phase = psel && penable && !pready;
        // completing edge of the access phase
        access_end = psel && penable && pready;
        // writes need the low byte lane; a cleared lane is ignored quietly
        wr_done = access_end && pwrite && mapped && pstrb[0];
        // per-register write strobes
        cc_write = wr_done && sel_cc;
        bank_write = wr_done && sel_bank;
        // unknown operation codes leave result and flags alone
        op_step = wr_done && sel_opn && alu.legal;
    end

    // storage address and allowed level
    // the address uses the pointer as it stands, so a pointer write is
    // complete before any later register access can use it
    always_comb begin
        // bank pointer high, register number low: consecutive eight-word banks
        mem_addr = gpr_addr(bank_pointer, paddr[2 +: REG_W]);
        // two-bit level field from the flag register
        allowed = {condition_code[CC_LEVEL_HIGH], condition_code[CC_LEVEL_LOW]};
    end

    // read multiplexer: selected register in the low bits, upper bits zero
    // storage read data lag the address by one clock; the address has stood
    // since the setup cycle, so they are settled in the first access cycle
    always_comb begin
        // zero unless a register is selected
        read_word = '0;
        if (sel_cc) begin
            // flags, level field and enable
            read_word[7:0] = condition_code;
        end else if (sel_bank) begin
            // active bank number
            read_word[BANK_W-1:0] = bank_pointer;
        end else if (sel_res) begin
            // last operation result
            read_word[7:0] = result;
        end else if (sel_stat) begin
            // accept line as the sequencer sees it
            read_word[0] = irq_accept;
        end else if (sel_gpr) begin
            // register of the active bank
            read_word[7:0] = mem_rdata;
        end else begin
            // write-only operation register and holes read zero
            read_word = '0;
        end
    end

    // bus answer: one wait state on every access
    // data and error stand only beside pready and are zero otherwise,
    // so a stale read word is never mistaken for a fresh one
    always_comb begin
        // defaults: no answer
        next_pready = data_phase;
        next_pslverr = 1'b0;
        next_prdata = '0;
        if (data_phase) begin
            // refused addresses answer with an error and zero data
            next_pslverr = !mapped;
            if (!pwrite && mapped) begin
                // read word captured for the answer cycle
                next_prdata = read_word;
            end
        end
    end

    // bus answer registers
    // outputs come straight from these flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // no answer pending
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // answer for one cycle only
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // flags and result: a software write replaces the flag register,
    // an operation step updates the five flags and keeps enable and level;
    // the two never meet, as each needs its own address
    always_comb begin
        // hold by default
        next_condition_code = condition_code;
        next_result = result;
        if (cc_write) begin
            // flags, level field and enable as written
            next_condition_code = pwdata[7:0];
        end else if (op_step) begin
            // result and its five flags
            next_result = alu.result;
            next_condition_code[CC_HALF_CARRY] = alu.half;
            next_condition_code[CC_NEGATIVE] = alu.neg;
            next_condition_code[CC_ZERO] = alu.zero;
            next_condition_code[CC_OVERFLOW] = alu.ovf;
            next_condition_code[CC_CARRY] = alu.carry;
        end
    end

    // flag and result registers
    // reset leaves interrupts off and the lowest level allowed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // enable cleared, level lowest
            condition_code <= CONDITION_CODE_RESET;
            result <= 8'h00;
        end else begin
            // held unless written or stepped
            condition_code <= next_condition_code;
            result <= next_result;
        end
    end

    // bank pointer: only a software write moves it
    // upper write data bits are dropped, every pointer value is a real bank
    always_comb begin
        // hold by default
        next_bank_pointer = bank_pointer;
        if (bank_write) begin
            // new active bank
            next_bank_pointer = pwdata[BANK_W-1:0];
        end
    end

    // bank pointer register
    // the first bank is active after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // first bank after reset
            bank_pointer <= BANK_POINTER_RESET;
        end else begin
            // held unless written
            bank_pointer <= next_bank_pointer;
        end
    end

    // interrupt gate: request level against the allowed level
    // codes 00 and 01 share the highest level, so an allowed code of 00
    // or 01 blocks every request; level 3 requests are never accepted
    always_comb begin
        // level numbers of both codes
        level_req = level_of(irq_level);
        level_allow = level_of(allowed);
        // strictly higher priority is a smaller level number
        level_above = (level_req < level_allow);
        // the request line is a level; the enable bit gates every request
        next_irq_accept = condition_code[CC_INT_ENABLE] && irq_req && level_above;
    end

    // accept register: one cycle behind its inputs
    // enable is clear after reset, so the gate stays shut until software opens it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // nothing accepted while in reset
            irq_accept <= 1'b0;
        end else begin
            // follows the gate
            irq_accept <= next_irq_accept;
        end
    end

endmodule // cpu_condition_flags

// >>> cpu_flags_properties.sv
// Purpose: port-level checks of the condition-flag block
// Assumes: sees only the top module ports, one clock domain
// Notes: bound into every instance of the top module
`timescale 1ns/1ps
module cpu_flags_properties
    import cpu_flags_pkg::*;
#(
    parameter int BANKS = BANK_COUNT,
    parameter int REGS = REGS_PER_BANK
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // interrupt gating
    input wire logic irq_req,
    input wire logic [1:0] irq_level,
    input wire logic irq_accept
);
    // one clock, one reset for all checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_one_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("pready not two cycles after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_no_ready_idle: assert property (!psel |=> !pready)
        else $error("pready without a request");
    a_error_with_ready: assert property (pslverr |-> pready && prdata == '0)
        else $error("error response malformed");
    a_rdata_idle: assert property (!pready |-> prdata == '0 && !pslverr)
        else $error("read data outside answer cycle");
    a_window_ok: assert property (pready && (paddr & GPR_WINDOW_MASK) == OFS_GPR_BASE
        && paddr[1:0] == 2'h0 |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("register window access refused or too wide");
    a_unmapped_err: assert property (pready && paddr >= 8'h40 |-> pslverr)
        else $error("unmapped address not refused");
    a_accept_cause: assert property (irq_accept |-> $past(irq_req))
        else $error("accept without a request");
    a_lowest_blocked: assert property (irq_accept |-> $past(irq_level) != 2'h3)
        else $error("lowest level request accepted");
    a_reset_blocks: assert property ($rose(presetn) |-> !irq_accept ##1 !irq_accept)
        else $error("accept right after reset");
endmodule // cpu_flags_properties

bind cpu_condition_flags cpu_flags_properties #(.BANKS(BANKS), .REGS(REGS)) u_cpu_flags_properties (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_req(irq_req), .irq_level(irq_level), .irq_accept(irq_accept));

// >>> tb.sv
// Purpose: self-checking bench of the condition-flag block
// Assumes: apb master in the bench, xorshift stimulus
// Notes: expectations come from bench functions, reset constants and inline expressions
`timescale 1ns/1ps
module tb
    import cpu_flags_pkg::*;
;
    // design ports
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req, irq_accept;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [1:0] irq_level;
    // bench state
    int bad_count, checks_done, i, j;
    logic [31:0] seed, rd, r;
    logic er, ci, ex;
    logic [7:0] a, b;
    logic [2:0] op;
    logic [12:0] e;
    logic [7:0] ca [6] = '{8'h80, 8'h0F, 8'h00, 8'h7F, 8'h80, 8'h01};
    logic [7:0] cb [6] = '{8'h80, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};

    cpu_condition_flags u_cpu_condition_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
        .irq_level(irq_level), .irq_accept(irq_accept));

    // free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // allowed or requested level number, smaller is higher
    function automatic int lv(input logic [1:0] c);
        return (c == 2'h0) ? 1 : int'(c);
    endfunction

    // expected {half, neg, zero, ovf, carry, result}
    function automatic logic [12:0] model(input logic [7:0] x, y, input logic [2:0] o,
                                          input logic cin);
        logic [8:0] s;
        logic [4:0] l;
        logic k, v;
        k = cin & o[0];
        v = 1'b0;
        l = 5'h0;
        case (o)
            3'h0, 3'h1: begin
                s = {1'b0, x} + y + k;
                l = {1'b0, x[3:0]} + y[3:0] + k;
                v = (x[7] == y[7]) && (s[7] != x[7]);
            end
            3'h2, 3'h3: begin
                s = {1'b0, x} - y - k;
                l = {1'b0, x[3:0]} - y[3:0] - k;
                v = (x[7] != y[7]) && (s[7] != x[7]);
            end
            3'h4: s = {x, 1'b0};
            default: s = {x[0], 1'b0, x[7:1]};
        endcase
        return {l[4], s[7], s[7:0] == 8'h00, v, s[8], s[7:0]};
    endfunction

    // compare and count
    task automatic check(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // counts, verdict, end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one apb transfer, result in rd and er
    task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 20) begin
            check({31'h0, pready}, 32'h1);
            complete_run();
        end
    endtask

    initial begin
        bad_count = 0; checks_done = 0; seed = 32'd82002;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; pstrb = 4'hF; irq_req = 1'b0; irq_level = 2'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        xfer(OFS_CONDITION_CODE, 1'b0, 32'h0);
        check(rd, 32'h30);
        xfer(OFS_BANK_POINTER, 1'b0, 32'h0);
        check(rd, 32'h0);
        $display("test reset values done");
        // arithmetic and shift steps, corners first
        for (i = 0; i < 48; i++) begin
            r = rnd();
            ci = r[8];
            op = (i < 6) ? 3'(i) : 3'(r[31:16] % 6);
            a = (i < 6) ? ca[i] : r[7:0];
            b = (i < 6) ? cb[i] : r[23:16];
            e = model(a, b, op, ci);
            xfer(OFS_CONDITION_CODE, 1'b1, {24'h0, 7'h18, ci});
            xfer(OFS_OPERATION, 1'b1, {13'h0, op, b, a});
            xfer(OFS_CONDITION_CODE, 1'b0, 32'h0);
            check(rd, {24'h0, e[12], 3'b011, e[11:8]});
            xfer(OFS_RESULT, 1'b0, 32'h0);
            check(rd, {24'h0, e[7:0]});
        end
        // unknown code, then a write with the low lane off: no effect
        xfer(OFS_OPERATION, 1'b1, 32'h0006FFFF);
        pstrb <= 4'hE;
        xfer(OFS_CONDITION_CODE, 1'b1, 32'hFF);
        pstrb <= 4'hF;
        xfer(OFS_CONDITION_CODE, 1'b0, 32'h0);
        check(rd, {24'h0, e[12], 3'b011, e[11:8]});
        xfer(OFS_RESULT, 1'b0, 32'h0);
        check(rd, {24'h0, e[7:0]});
        $display("test flags done");
        // every request line, enable, allowed level and request level
        for (j = 0; j < 64; j++) begin
            xfer(OFS_CONDITION_CODE, 1'b1, {25'h0, j[4], j[3:2], 4'h0});
            irq_level <= j[1:0];
            irq_req <= j[5];
            ex = j[5] && j[4] && lv(j[1:0]) < lv(j[3:2]);
            repeat (2) @(posedge pclk);
            check({31'h0, irq_accept}, {31'h0, ex});
            xfer(OFS_STATUS, 1'b0, 32'h0);
            check(rd, {31'h0, ex});
        end
        // reset in mid-run while accepting
        xfer(OFS_CONDITION_CODE, 1'b1, 32'h70);
        irq_level <= 2'h0;
        repeat (2) @(posedge pclk);
        check({31'h0, irq_accept}, 32'h1);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        xfer(OFS_CONDITION_CODE, 1'b0, 32'h0);
        check(rd, 32'h30);
        check({31'h0, irq_accept}, 32'h0);
        irq_req <= 1'b0;
        $display("test interrupts done");
        // one register per bank, read back after all banks written
        for (j = 0; j < 64; j++) begin
            xfer(OFS_BANK_POINTER, 1'b1, 32'(j % 32));
            xfer(OFS_GPR_BASE | {3'h0, j[2:0], 2'h0}, j < 32, {24'h0, j[7:0] ^ 8'hA5});
            if (j >= 32)
                check(rd, {24'h0, 3'h0, j[4:0]} ^ 32'hA5);
        end
        xfer(8'h40, 1'b0, 32'h0);
        check({er, rd[30:0]}, 32'h80000000);
        $display("test banks done");
        complete_run();
    end
endmodule // tb
